// File: bench/test_ucr_request_wake.sv
// Self-checking bench for the serial request, interrupt and wake block
`timescale 1ns/10ps
`default_nettype none
module test_ucr_request_wake;
  import ucr_pkg::*;
  localparam int STG = 4;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, rxPush, errSeen;
  logic ctsLevel, rxSFull, rxFFull, lastWord, lenDone, busy, sleepReq;
  logic dWr, dRd, cSr, cEn, cRx, cTx, clkOn, rxDrop, wake, dmaRx, dmaTx, irq;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd, ra, rc;
  logic [4:0] ev, rxCount, txFree;
  logic [15:0] txData, rxData;
  int n_errors = 0;
  int compares = 0;
  int seed = 32'h99669F86;
  int txLeft = FIFO_DEPTH;
  int i, m;
  int fpos[5] = '{IF_TXDONE, IF_RXSTART, IF_CTSCHG, IF_BREAK, IF_ERROR};
  ucr_request_wake #(.STAGES(STG)) DUT (
    .clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxCount(rxCount), .txFree(txFree), .rxData(rxData), .txDoneEv(ev[0]),
    .rxStartEv(ev[1]), .ctsChangeEv(ev[2]), .ctsLevel(ctsLevel), .breakEv(ev[3]),
    .errorEv(ev[4]), .rxShifterFull(rxSFull), .rxFifoFull(rxFFull),
    .lastWordAvail(lastWord), .frameLenDone(lenDone), .transferBusy(busy),
    .txData(txData), .dataWrStrobe(dWr), .dataRdStrobe(dRd), .coreSoftReset(cSr),
    .coreEnable(cEn), .coreRxOn(cRx), .coreTxOn(cTx), .sleepReq(sleepReq),
    .coreClkOn(clkOn), .rxDropAll(rxDrop), .wakeReq(wake), .dmaRxReq(dmaRx),
    .dmaTxReq(dmaTx), .irq(irq));
  ucr_line_model uLine (
    .clk(clk), .rst(rst), .rxPush(rxPush), .dataRdStrobe(dRd), .dataWrStrobe(dWr),
    .rxCount(rxCount), .txFree(txFree), .rxData(rxData));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Compare a register value
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Compare an output pin
  task automatic chkPin(input logic got, input logic exp);
    chkReg({31'h0, got}, {31'h0, exp});
  endtask
  // Expected enable mask after a set then a clear
  function automatic logic [31:0] expEnable(input logic [31:0] s, input logic [31:0] c);
    return {24'h0, s[7:0] & ~c[7:0] & IF_MASK};
  endfunction
  // One bus transfer held until ready is seen
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    chkPin(pready, 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic fire(input int k);
    @(posedge clk);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev <= '0;
  endtask
  task automatic push;
    @(posedge clk);
    rxPush <= 1'b1;
    @(posedge clk);
    rxPush <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    repeat (6000) @(posedge clk);
    n_errors++;
    results;
  end
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, rxPush, ctsLevel, rxSFull, rxFFull, lastWord, lenDone, busy,
      sleepReq, paddr, pwdata, ev} = '0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    ctsLevel <= 1'($random(seed));
    repeat (4)
    begin
      ra = $random(seed);
      rc = $random(seed);
      apb(1'b1, IDX_IENSET, ra);
      apb(1'b1, IDX_IENCLR, rc);
      apb(1'b0, IDX_IENSET, 32'h0);
      chkReg(rd, expEnable(ra, rc));
      apb(1'b1, IDX_IENCLR, 32'hFF);
    end
    for (i = 0; i < 5; i++)
    begin
      fire(i);
      apb(1'b0, IDX_IFLAGS, 32'h0);
      chkReg(rd, (32'h1 << IF_TXEMPTY) | (32'h1 << fpos[i]));
      apb(1'b1, IDX_IENSET, 32'h1 << fpos[i]);
      tick(2);
      chkPin(irq, 1'b1);
      apb(1'b1, IDX_IENCLR, 32'h1 << fpos[i]);
      tick(2);
      chkPin(irq, 1'b0);
      apb(1'b1, IDX_IENSET, 32'h1 << fpos[i]);
      apb(1'b1, IDX_IFLAGS, 32'h1 << fpos[i]);
      tick(2);
      chkPin(irq, 1'b0);
      apb(1'b1, IDX_IENCLR, 32'hFF);
    end
    apb(1'b0, 8'hFF, 32'h0);
    chkReg(rd, 32'h0);
    chkPin(errSeen, 1'b1);
    $display("test flags done");
    chkPin(dmaTx, 1'b1);
    chkPin(dmaRx, 1'b0);
    push;
    tick(3);
    chkPin(dmaRx, 1'b1);
    apb(1'b0, IDX_DATA, 32'h0);
    tick(4);
    chkPin(dmaRx, 1'b0);
    apb(1'b1, IDX_DATA, ra);
    txLeft--;
    tick(1);
    chkReg({16'h0, txData}, {16'h0, ra[15:0]});
    $display("test single buffer done");
    apb(1'b1, IDX_FIFOCTL, {11'h0, 5'(txLeft), 3'h0, 5'h3, 7'h0, 1'b1});
    for (i = 1; i <= 3; i++)
    begin
      push;
      tick(3);
      chkPin(dmaRx, i >= 3);
    end
    chkPin(dmaTx, 1'b1);
    apb(1'b1, IDX_DATA, 32'h0);
    tick(4);
    chkPin(dmaTx, 1'b0);
    repeat (3) apb(1'b0, IDX_DATA, 32'h0);
    push;
    apb(1'b1, IDX_IFLAGS, 32'hFF);
    apb(1'b0, IDX_IFLAGS, 32'h0);
    chkPin(rd[IF_RXDONE], 1'b0);
    lastWord <= 1'b1;
    lenDone <= 1'b1;
    apb(1'b0, IDX_IFLAGS, 32'h0);
    chkPin(rd[IF_RXDONE], 1'b1);
    {lastWord, lenDone, rxSFull, rxFFull} <= 4'hF;
    tick(3);
    {lastWord, lenDone, rxSFull, rxFFull} <= 4'h0;
    apb(1'b0, IDX_IFLAGS, 32'h0);
    chkPin(rd[IF_ERROR], 1'b1);
    apb(1'b0, IDX_STATUS, 32'h0);
    chkPin(rd[ST_OVF], 1'b1);
    chkPin(rd[ST_CTS], ctsLevel);
    apb(1'b1, IDX_FIFOCTL, 32'h0);
    $display("test fifo done");
    apb(1'b1, IDX_CPRI, 32'h2);
    apb(1'b0, IDX_SYNCPEND, 32'h0);
    chkPin(rd[SB_ENABLE], 1'b1);
    tick(STG + 4);
    chkPin(cEn, 1'b1);
    apb(1'b0, IDX_SYNCPEND, 32'h0);
    chkReg(rd, 32'h0);
    apb(1'b1, IDX_CSEC, 32'h0003_0000);
    apb(1'b0, IDX_SYNCPEND, 32'h0);
    chkPin(rd[SB_CSEC], 1'b1);
    tick(STG + 5);
    chkReg({30'h0, cRx, cTx}, 32'h3);
    $display("test sync done");
    apb(1'b1, IDX_IENSET, (32'h1 << IF_TXDONE) | (32'h1 << IF_RXSTART));
    for (m = 0; m < 4; m++)
    begin
      apb(1'b1, IDX_CPRI, {24'h0, m[1], 4'h0, ~m[0], 2'h2});
      busy <= 1'b1;
      sleepReq <= 1'b1;
      tick(4);
      chkPin(clkOn, 1'b1);
      busy <= 1'b0;
      tick(6);
      chkPin(clkOn, m[1]);
      chkPin(rxDrop, !m[1] && m[0]);
      fire(0);
      tick(3);
      chkPin(wake, m == 2);
      fire(1);
      tick(3);
      chkPin(wake, m != 1);
      sleepReq <= 1'b0;
      apb(1'b1, IDX_IFLAGS, 32'hFF);
      tick(4);
    end
    $display("test sleep done");
    apb(1'b1, IDX_IENSET, 32'hFF);
    apb(1'b1, IDX_CPRI, 32'h1);
    tick(STG + 6);
    chkPin(irq, 1'b0);
    chkPin(cEn, 1'b0);
    apb(1'b0, IDX_IENSET, 32'h0);
    chkReg(rd, 32'h0);
    $display("test soft reset done");
    results;
  end
endmodule
`default_nettype wire

// File: bench/ucr_line_model.sv
// Behavioural far-side datapath: receive words, transmit space, data
`timescale 1ns/10ps
`default_nettype none
module ucr_line_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Traffic from the line and block accesses
  input wire logic rxPush,
  input wire logic dataRdStrobe,
  input wire logic dataWrStrobe,
  // Status back to the block
  output logic [ucr_pkg::CNT_W-1:0] rxCount,
  output logic [ucr_pkg::CNT_W-1:0] txFree,
  output logic [15:0] rxData
);
  import ucr_pkg::*;
  // Words waiting; each read takes one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rxCount <= '0;
    else
      rxCount <= rxCount + CNT_W'(rxPush) - CNT_W'(dataRdStrobe && rxCount != 0);
  end
  // Transmit side stalled: space only shrinks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      txFree <= CNT_W'(FIFO_DEPTH);
    else if (dataWrStrobe && txFree != 0)
      txFree <= txFree - 1'b1;
  end
  // Data lines change every cycle so stale values never match
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rxData <= 16'h5A3C;
    else
      rxData <= {rxData[14:0], ~rxData[15]} ^ 16'h1D0B;
  end
endmodule
`default_nettype wire

// File: bench/ucr_request_wake_properties.sv
// Port-level checks for the serial request and wake block
`timescale 1ns/10ps
`default_nettype none
module ucr_request_wake_properties #(
  parameter int STAGES = ucr_pkg::SYNC_STAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucr_pkg::ADDR_W-1:0] paddr,
  input wire logic [ucr_pkg::DATA_W-1:0] pwdata,
  input wire logic pready,
  // Block side
  input wire logic transferBusy,
  input wire logic sleepReq,
  input wire logic dataWrStrobe,
  input wire logic dataRdStrobe,
  input wire logic coreSoftReset,
  input wire logic coreEnable,
  input wire logic coreClkOn,
  input wire logic rxDropAll,
  input wire logic wakeReq,
  input wire logic dmaRxReq,
  input wire logic dmaTxReq,
  input wire logic irq
);
  import ucr_pkg::*;
  localparam int SYNC_MAX = STAGES + 6;
  localparam logic [9:0] A_DATA = {IDX_DATA, 2'b00};
  localparam logic [9:0] A_CLR = {IDX_IENCLR, 2'b00};
  localparam logic [9:0] A_CTL = {IDX_CPRI, 2'b00};
  // Completed transfers of interest
  wire logic acc = psel && penable && pready;
  wire logic enWr = acc && pwrite && paddr == A_CTL && pwdata[1:0] == 2'b10;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Bus answer timing, data access side effects, interrupt line, sleep, sync
  a_one_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after penable");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_rx_drop: assert property (acc && !pwrite && paddr == A_DATA |-> ##[1:2] !dmaRxReq)
    else $error("rx request kept after data read");
  a_tx_drop: assert property (acc && pwrite && paddr == A_DATA |-> ##[1:2] !dmaTxReq)
    else $error("tx request kept after data write");
  a_rd_strobe: assert property (acc && !pwrite && paddr == A_DATA |=> dataRdStrobe)
    else $error("no read strobe after data read");
  a_wr_strobe: assert property (acc && pwrite && paddr == A_DATA |=> dataWrStrobe)
    else $error("no write strobe after data write");
  a_irq_off: assert property (acc && pwrite && paddr == A_CLR && pwdata[7:0] == 8'hFF |-> ##2 !irq)
    else $error("irq stays after all enables cleared");
  a_soft_reset_irq: assert property (coreSoftReset |-> ##3 !irq)
    else $error("irq stays after soft reset");
  a_gate_late: assert property ($fell(coreClkOn) |-> $past(sleepReq, 2) && !$past(transferBusy, 2))
    else $error("clock gated during transfer or while awake");
  a_drop_asleep: assert property (rxDropAll |-> sleepReq || $past(sleepReq) || $past(sleepReq, 2))
    else $error("reception dropped while awake");
  a_sync_late: assert property (enWr && !coreEnable |=> !coreEnable [*2] ##[1:SYNC_MAX] coreEnable)
    else $error("enable not applied through synchroniser");
  a_soft_reset_pulse: assert property (coreSoftReset |=> !coreSoftReset)
    else $error("soft reset strobe longer than one cycle");
  // Main scenarios reached
  c_irq: cover property ($rose(irq));
  c_gate: cover property ($fell(coreClkOn));
  c_wake: cover property ($rose(wakeReq));
endmodule
bind ucr_request_wake ucr_request_wake_properties #(.STAGES(STAGES)) uProps (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .transferBusy(transferBusy), .sleepReq(sleepReq),
  .dataWrStrobe(dataWrStrobe), .dataRdStrobe(dataRdStrobe), .coreSoftReset(coreSoftReset),
  .coreEnable(coreEnable), .coreClkOn(coreClkOn), .rxDropAll(rxDropAll), .wakeReq(wakeReq),
  .dmaRxReq(dmaRxReq), .dmaTxReq(dmaTxReq), .irq(irq));
`default_nettype wire

// File: src/ucr_pkg.sv
// Shared constants for the serial request, interrupt and wake block
`default_nettype none
package ucr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int CNT_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 3;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CPRI = 8'h00;
  localparam logic [7:0] IDX_CSEC = 8'h04;
  localparam logic [7:0] IDX_BAUD = 8'h0C;
  localparam logic [7:0] IDX_RXPULSE = 8'h0E;
  localparam logic [7:0] IDX_IENCLR = 8'h14;
  localparam logic [7:0] IDX_IENSET = 8'h16;
  localparam logic [7:0] IDX_IFLAGS = 8'h18;
  localparam logic [7:0] IDX_STATUS = 8'h1A;
  localparam logic [7:0] IDX_SYNCPEND = 8'h1C;
  localparam logic [7:0] IDX_FIFOCTL = 8'h20;
  localparam logic [7:0] IDX_DATA = 8'h28;
  localparam logic [7:0] IDX_DBG = 8'h30;
  localparam logic [7:0] IDX_FIFOFREE = 8'h34;
  // control_primary fields
  localparam int CA_SOFTRST = 0;
  localparam int CA_ENABLE = 1;
  localparam int CA_MODE_LSB = 2;
  localparam int CA_RUNSTBY = 7;
  localparam logic [2:0] MODE_EXT_CLK = 3'h0;
  localparam logic [31:0] CPRI_RESET = 32'h0000_0000;
  localparam logic [31:0] CPRI_WMASK = 32'h7FF3_E19F;
  // control_secondary fields
  localparam int CB_TXON = 16;
  localparam int CB_RXON = 17;
  localparam logic [31:0] CSEC_RESET = 32'h0000_0000;
  localparam logic [31:0] CSEC_WMASK = 32'h0003_3747;
  // FIFO control fields
  localparam int FC_ON = 0;
  localparam int FC_RXTHR_LSB = 8;
  localparam int FC_TXTHR_LSB = 16;
  localparam logic [31:0] FIFOCTL_RESET = 32'h0000_0000;
  // Interrupt flag positions
  localparam int IF_TXEMPTY = 0;
  localparam int IF_TXDONE = 1;
  localparam int IF_RXDONE = 2;
  localparam int IF_RXSTART = 3;
  localparam int IF_CTSCHG = 4;
  localparam int IF_BREAK = 5;
  localparam int IF_ERROR = 7;
  localparam logic [7:0] IF_MASK = 8'hBF;
  localparam logic [7:0] IF_RXWAKE = 8'h0C;
  // Status and sync busy fields
  localparam int ST_OVF = 2;
  localparam int ST_CTS = 3;
  localparam int SB_SOFTRST = 0;
  localparam int SB_ENABLE = 1;
  localparam int SB_CSEC = 2;
endpackage
`default_nettype wire

// File: src/ucr_request_wake.sv
// Serial port DMA requests, interrupt flags, sleep and wake, write sync
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module ucr_request_wake #(
  parameter int DEPTH = ucr_pkg::FIFO_DEPTH,
  parameter int STAGES = ucr_pkg::SYNC_STAGES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ucr_pkg::ADDR_W-1:0] paddr,
  input wire logic [ucr_pkg::DATA_W-1:0] pwdata,
  output logic [ucr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Datapath status
  input wire logic [ucr_pkg::CNT_W-1:0] rxCount,
  input wire logic [ucr_pkg::CNT_W-1:0] txFree,
  input wire logic [15:0] rxData,
  input wire logic txDoneEv,
  input wire logic rxStartEv,
  input wire logic ctsChangeEv,
  input wire logic ctsLevel,
  input wire logic breakEv,
  input wire logic errorEv,
  input wire logic rxShifterFull,
  input wire logic rxFifoFull,
  input wire logic lastWordAvail,
  input wire logic frameLenDone,
  input wire logic transferBusy,
  // Datapath access
  output logic [15:0] txData,
  output logic dataWrStrobe,
  output logic dataRdStrobe,
  // Core domain controls
  output logic coreSoftReset,
  output logic coreEnable,
  output logic coreRxOn,
  output logic coreTxOn,
  // Sleep and wake
  input wire logic sleepReq,
  output logic coreClkOn,
  output logic rxDropAll,
  output logic wakeReq,
  // Requests
  output logic dmaRxReq,
  output logic dmaTxReq,
  output logic irq
);
  import ucr_pkg::*;

  // Address match against a register index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic [31:0] control_primary_q;
  logic [31:0] control_secondary_q;
  logic [31:0] fifoCtl_q;
  logic [15:0] baud_q;
  logic [7:0] rxPulse_q;
  logic dbgStop_q;
  logic [7:0] ienable_q;
  logic [7:0] iflags_q;
  logic buffer_overflow_q;
  logic gated_q;
  logic access;
  logic commit;
  logic wrCommit;
  logic rdCommit;
  logic mapped;
  logic softRst;
  logic [31:0] rdValue;
  logic [7:0] flagSet;
  logic fifoOn;
  logic extClk;
  logic runStby;
  logic rxCond;
  logic txCond;
  logic overflow;
  logic [7:0] wakeMask;
  logic [2:0] syncLoad;
  logic [2:0] syncApply;
  logic [2:0] sync_pending;
  logic [1:0] syncVal [3];

  // APB phases: one wait cycle, then completion
  assign access = psel & penable;
  assign commit = access & pready;
  assign wrCommit = commit & pwrite;
  assign rdCommit = commit & ~pwrite;
  assign fifoOn = fifoCtl_q[FC_ON];
  assign extClk = (control_primary_q[CA_MODE_LSB +: 3] == MODE_EXT_CLK);
  assign runStby = control_primary_q[CA_RUNSTBY];

  // Address decode and read data
  always_comb
  begin
    mapped = 1'b1;
    rdValue = 32'h0000_0000;
    if (hit(paddr, IDX_CPRI))
      rdValue = control_primary_q;
    else if (hit(paddr, IDX_CSEC))
      rdValue = control_secondary_q;
    else if (hit(paddr, IDX_BAUD))
      rdValue = {16'h0000, baud_q};
    else if (hit(paddr, IDX_RXPULSE))
      rdValue = {24'h00_0000, rxPulse_q};
    else if (hit(paddr, IDX_IENCLR) || hit(paddr, IDX_IENSET))
      rdValue = {24'h00_0000, ienable_q};
    else if (hit(paddr, IDX_IFLAGS))
      rdValue = {24'h00_0000, iflags_q};
    else if (hit(paddr, IDX_STATUS))
    begin
      rdValue[ST_OVF] = buffer_overflow_q;
      rdValue[ST_CTS] = ctsLevel;
    end
    else if (hit(paddr, IDX_SYNCPEND))
      rdValue = {29'h0000_0000, sync_pending};
    else if (hit(paddr, IDX_FIFOCTL))
      rdValue = fifoCtl_q;
    else if (hit(paddr, IDX_DATA))
      rdValue = {16'h0000, rxData};
    else if (hit(paddr, IDX_DBG))
      rdValue = {31'h0000_0000, dbgStop_q};
    else if (hit(paddr, IDX_FIFOFREE))
      rdValue = {19'h0_0000, rxCount, 3'h0, txFree};
    else
      mapped = 1'b0;
  end

  // Bus answer; data and error captured in the wait cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      pready <= access & ~pready;
      if (access && !pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rdValue;
        pslverr <= ~mapped;
      end
    end
  end

  // control writes go through the core crossing
  assign syncLoad[SB_SOFTRST] = wrCommit & hit(paddr, IDX_CPRI);
  assign syncLoad[SB_ENABLE] = wrCommit & hit(paddr, IDX_CPRI);
  assign syncLoad[SB_CSEC] = wrCommit & hit(paddr, IDX_CSEC);

  generate
    for (genvar i = 0; i < 3; i++)
    begin : g_sync
      logic [1:0] loadBits;
      if (i == SB_SOFTRST)
        assign loadBits = {1'b0, pwdata[CA_SOFTRST]};
      else if (i == SB_ENABLE)
        assign loadBits = {1'b0, pwdata[CA_ENABLE]};
      else
        assign loadBits = {pwdata[CB_RXON], pwdata[CB_TXON]};
      ucr_write_sync #(.STAGES(STAGES), .WIDTH(2)) u_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .load(syncLoad[i]),
        .loadValue(loadBits),
        .applyPulse(syncApply[i]),
        .applyValue(syncVal[i]),
        .busy(sync_pending[i])
      );
    end
  endgenerate

  // Soft reset acts once its write reaches the core
  assign softRst = syncApply[SB_SOFTRST] & syncVal[SB_SOFTRST][0];

  // Control registers as software sees them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      control_primary_q <= CPRI_RESET;
      control_secondary_q <= CSEC_RESET;
      fifoCtl_q <= FIFOCTL_RESET;
    end
    else if (ce)
    begin
      if (softRst)
      begin
        control_primary_q <= CPRI_RESET;
        control_secondary_q <= CSEC_RESET;
        fifoCtl_q <= FIFOCTL_RESET;
      end
      else if (wrCommit)
      begin
        if (hit(paddr, IDX_CPRI))
          control_primary_q <= pwdata & CPRI_WMASK;
        else if (hit(paddr, IDX_CSEC))
          control_secondary_q <= pwdata & CSEC_WMASK;
        else if (hit(paddr, IDX_FIFOCTL))
          fifoCtl_q <= pwdata;
      end
    end
  end

  // Plain storage registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      baud_q <= 16'h0000;
      rxPulse_q <= 8'h00;
      dbgStop_q <= 1'b0;
    end
    else if (ce)
    begin
      if (softRst)
      begin
        baud_q <= 16'h0000;
        rxPulse_q <= 8'h00;
        dbgStop_q <= 1'b0;
      end
      else if (wrCommit)
      begin
        if (hit(paddr, IDX_BAUD))
          baud_q <= pwdata[15:0];
        else if (hit(paddr, IDX_RXPULSE))
          rxPulse_q <= pwdata[7:0];
        else if (hit(paddr, IDX_DBG))
          dbgStop_q <= pwdata[0];
      end
    end
  end

  // Core copies updated only when their write lands
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      coreSoftReset <= 1'b0;
      coreEnable <= 1'b0;
      coreRxOn <= 1'b0;
      coreTxOn <= 1'b0;
    end
    else if (ce)
    begin
      coreSoftReset <= softRst;
      if (softRst)
      begin
        coreEnable <= 1'b0;
        coreRxOn <= 1'b0;
        coreTxOn <= 1'b0;
      end
      else
      begin
        if (syncApply[SB_ENABLE])
          coreEnable <= syncVal[SB_ENABLE][0];
        if (syncApply[SB_CSEC])
        begin
          coreTxOn <= syncVal[SB_CSEC][0];
          coreRxOn <= syncVal[SB_CSEC][1];
        end
      end
    end
  end

  // no-FIFO receive waits on any word
  // FIFO receive waits on threshold fill
  assign rxCond = fifoOn ? (rxCount >= fifoCtl_q[FC_RXTHR_LSB +: CNT_W]) : (rxCount != '0);
  // no-FIFO transmit waits on any free space
  // FIFO transmit waits on threshold free
  assign txCond = fifoOn ? (txFree >= fifoCtl_q[FC_TXTHR_LSB +: CNT_W]) : (txFree != '0);
  assign overflow = fifoOn & rxShifterFull & rxFifoFull;

  // DMA requests dropped by the matching data access
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dmaRxReq <= 1'b0;
      dmaTxReq <= 1'b0;
    end
    else if (ce)
    begin
      dmaRxReq <= rxCond & ~(rdCommit & hit(paddr, IDX_DATA)) & ~softRst;
      dmaTxReq <= txCond & ~(wrCommit & hit(paddr, IDX_DATA)) & ~softRst;
    end
  end

  // Data register strobes toward the datapath
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dataWrStrobe <= 1'b0;
      dataRdStrobe <= 1'b0;
      txData <= 16'h0000;
    end
    else if (ce)
    begin
      dataWrStrobe <= wrCommit & hit(paddr, IDX_DATA);
      dataRdStrobe <= rdCommit & hit(paddr, IDX_DATA);
      if (wrCommit && hit(paddr, IDX_DATA))
        txData <= pwdata[15:0];
    end
  end

  always_comb
  begin
    flagSet = 8'h00;
    flagSet[IF_TXEMPTY] = txCond;
    flagSet[IF_RXDONE] = rxCond | (fifoOn & lastWordAvail & frameLenDone);
    flagSet[IF_TXDONE] = txDoneEv & (~fifoOn | (txFree == CNT_W'(DEPTH)));
    flagSet[IF_RXSTART] = rxStartEv;
    flagSet[IF_CTSCHG] = ctsChangeEv;
    flagSet[IF_BREAK] = breakEv;
    flagSet[IF_ERROR] = errorEv | overflow;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      iflags_q <= 8'h00;
    else if (ce)
    begin
      if (softRst)
        iflags_q <= 8'h00;
      else if (wrCommit && hit(paddr, IDX_IFLAGS))
        iflags_q <= ((iflags_q & ~pwdata[7:0]) | flagSet) & IF_MASK;
      else
        iflags_q <= (iflags_q | flagSet) & IF_MASK;
    end
  end

  // sticky overflow, cleared by writing one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      buffer_overflow_q <= 1'b0;
    else if (ce)
    begin
      if (softRst)
        buffer_overflow_q <= 1'b0;
      else if (overflow)
        buffer_overflow_q <= 1'b1;
      else if (wrCommit && hit(paddr, IDX_STATUS) && pwdata[ST_OVF])
        buffer_overflow_q <= 1'b0;
    end
  end

  // enable set and clear by ones
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ienable_q <= 8'h00;
    else if (ce)
    begin
      if (softRst)
        ienable_q <= 8'h00;
      else if (wrCommit && hit(paddr, IDX_IENSET))
        ienable_q <= (ienable_q | pwdata[7:0]) & IF_MASK;
      else if (wrCommit && hit(paddr, IDX_IENCLR))
        ienable_q <= ienable_q & ~pwdata[7:0];
    end
  end

  // interrupt while any enabled flag stands
  // level output needs no bus cycle to hold
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else if (ce)
      irq <= |(iflags_q & ienable_q);
  end

  // Which flags may wake the system in sleep
  always_comb
  begin
    wakeMask = IF_MASK;
    if (sleepReq)
    begin
      // internal clock in standby, all wake
      if (!extClk && runStby)
        wakeMask = IF_MASK;
      // external clock in standby, rx only
      else if (extClk && runStby)
        wakeMask = IF_RXWAKE;
      // internal clock gated, rx still wakes
      else if (!extClk)
        wakeMask = IF_RXWAKE;
      else
        wakeMask = 8'h00;
    end
  end

  // gate only once the transfer is over
  // disconnect after the transfer, and drop in the same cycle with external clock only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      gated_q <= 1'b0;
    else if (ce)
    begin
      if (!sleepReq || runStby)
        gated_q <= 1'b0;
      else if (!transferBusy)
        gated_q <= 1'b1;
    end
  end

  // Sleep and wake outputs
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      coreClkOn <= 1'b1;
      rxDropAll <= 1'b0;
      wakeReq <= 1'b0;
    end
    else if (ce)
    begin
      coreClkOn <= ~gated_q;
      rxDropAll <= gated_q & extClk;
      wakeReq <= sleepReq & |(iflags_q & ienable_q & wakeMask);
    end
  end

  // only event inputs exist on this block, no event outputs
endmodule
`default_nettype wire

// File: src/ucr_write_sync.sv
// Carries one control write across into the core domain with a busy flag
`timescale 1ns/10ps
`default_nettype none
module ucr_write_sync #(
  parameter int STAGES = ucr_pkg::SYNC_STAGES,
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Bus side
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  // Core side
  output logic applyPulse,
  output logic [WIDTH-1:0] applyValue,
  output logic busy
);
  import ucr_pkg::*;

  logic [STAGES-1:0] pipe_q;

  // Travel delay; a new write restarts the trip
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pipe_q <= '0;
    else if (ce)
      pipe_q <= load ? {{(STAGES-1){1'b0}}, 1'b1} : {pipe_q[STAGES-2:0], 1'b0};
  end

  // Value held for the core while in flight
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      applyValue <= '0;
    else if (ce && load)
      applyValue <= loadValue;
  end

  // Apply strobe at the end of the trip
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      applyPulse <= 1'b0;
    else if (ce)
      applyPulse <= pipe_q[STAGES-1] & ~load;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      busy <= 1'b0;
    else if (ce)
    begin
      if (load)
        busy <= 1'b1;
      else if (applyPulse)
        busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire
